// file: io_ports_cfg.svh
`ifndef IO_PORTS_CFG_SVH
`define IO_PORTS_CFG_SVH

// register addresses in data memory
`define ADDR_PA_DATA 8'h00
`define ADDR_PA_DIR 8'h01
`define ADDR_PA_PU 8'h02
`define ADDR_PA_WAKE 8'h03
`define ADDR_PB_DATA 8'h04
`define ADDR_PB_DIR 8'h05
`define ADDR_PB_PU 8'h06
`define ADDR_PC_DATA 8'h07
`define ADDR_PC_DIR 8'h08
`define ADDR_PC_PU 8'h09
`define ADDR_PD_DATA 8'h0A
`define ADDR_PD_DIR 8'h0B
`define ADDR_PD_PU 8'h0C
`define ADDR_PE_DATA 8'h0D
`define ADDR_PE_DIR 8'h0E
`define ADDR_PE_PU 8'h0F
`define ADDR_SRC_AB 8'h10
`define ADDR_SRC_CD 8'h11
`define ADDR_SRC_MISC 8'h12

// implemented bits of ports e..a
`define IMPL_MASK 40'h0FFFFFFFFF
`define DATA_RST 40'h0FFFFFFFFF
`define DIR_RST 40'h0FFFFFFFFF
`define PU_RST 40'h0000000000
`define WAKE_RST 8'h00
`define SRC_RST 8'h00
`define SRC_MISC_MASK 8'h03
`define PIN_HIGH_RST 8'hFF
`define RDATA_RST 8'h00
`define SRC_OFF 2'h0

`endif

// file: io_ports_pkg.sv
package io_ports_pkg;

  typedef logic [7:0] byte_t;
  typedef logic [1:0] src_level_t;

  typedef enum {
    port_a,
    port_b,
    port_c,
    port_d,
    port_e
  } port_id_e;

  localparam int unsigned num_ports = 5;

endpackage

// file: io_pin_cell.sv
`timescale 1ns/100ps
`default_nettype none
`include "io_ports_cfg.svh"

module io_pin_cell #(
  parameter int unsigned W = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] dir,
  input wire logic [W-1:0] latch,
  input wire logic [W-1:0] pu,
  input wire logic [W/2-1:0] src,
  output logic [W-1:0] pin_out,
  output logic [W-1:0] pin_oe,
  output logic [W-1:0] pu_en,
  output logic [2*W-1:0] src_sel
);

  logic [2*W-1:0] src_d;

  // one two-bit field per group of four pins, live only on outputs
  for (genvar i = 0; i < W; i++) begin : g_src
    assign src_d[2*i +: 2] = dir[i] ? `SRC_OFF : src[2*(i/4) +: 2];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_out <= '0;
      pin_oe <= '0;
    end else begin
      pin_out <= latch;
      pin_oe <= ~dir;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pu_en <= '0;
      src_sel <= '0;
    end else begin
      pu_en <= pu & dir;
      src_sel <= src_d;
    end
  end

endmodule

`default_nettype wire

// file: bidir_io_ports.sv
`timescale 1ns/100ps
`default_nettype none
`include "io_ports_cfg.svh"

module bidir_io_ports (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic sleep_mode,
  output logic wake_req,
  input wire logic [7:0] pa_in,
  output logic [7:0] pa_out,
  output logic [7:0] pa_oe,
  output logic [7:0] pa_pu_en,
  output logic [15:0] pa_src_sel,
  input wire logic [7:0] pb_in,
  output logic [7:0] pb_out,
  output logic [7:0] pb_oe,
  output logic [7:0] pb_pu_en,
  output logic [15:0] pb_src_sel,
  input wire logic [7:0] pc_in,
  output logic [7:0] pc_out,
  output logic [7:0] pc_oe,
  output logic [7:0] pc_pu_en,
  output logic [15:0] pc_src_sel,
  input wire logic [7:0] pd_in,
  output logic [7:0] pd_out,
  output logic [7:0] pd_oe,
  output logic [7:0] pd_pu_en,
  output logic [15:0] pd_src_sel,
  input wire logic [3:0] pe_in,
  output logic [3:0] pe_out,
  output logic [3:0] pe_oe,
  output logic [3:0] pe_pu_en,
  output logic [7:0] pe_src_sel
);

  localparam logic [4:0][7:0] impl = `IMPL_MASK;

  logic [4:0][7:0] dat_q;
  logic [4:0][7:0] dir_q;
  logic [4:0][7:0] pu_q;
  logic [4:0][7:0] pin;
  logic [4:0][7:0] port_rd;
  io_ports_pkg::byte_t wake_q;
  io_ports_pkg::byte_t src_ab_q;
  io_ports_pkg::byte_t src_cd_q;
  io_ports_pkg::byte_t src_misc_q;
  io_ports_pkg::byte_t pa_prev_q;
  io_ports_pkg::byte_t pa_fall;
  io_ports_pkg::byte_t rd_val;
  logic [4:0] wr_dat;
  logic [4:0] wr_dir;
  logic [4:0] wr_pu;
  logic wr_wake;
  logic wr_s0;
  logic wr_s1;
  logic wr_s2;
  logic wake_req_q;

  assign pin[0] = pa_in;
  assign pin[1] = pb_in;
  assign pin[2] = pc_in;
  assign pin[3] = pd_in;
  assign pin[4] = {4'h0, pe_in};

  // write decode
  always_comb begin
    wr_dat = '0;
    wr_dir = '0;
    wr_pu = '0;
    wr_wake = 1'b0;
    wr_s0 = 1'b0;
    wr_s1 = 1'b0;
    wr_s2 = 1'b0;
    if (reg_addr == `ADDR_PA_DATA) begin
      wr_dat[0] = reg_wr;
    end else if (reg_addr == `ADDR_PA_DIR) begin
      wr_dir[0] = reg_wr;
    end else if (reg_addr == `ADDR_PA_PU) begin
      wr_pu[0] = reg_wr;
    end else if (reg_addr == `ADDR_PA_WAKE) begin
      wr_wake = reg_wr;
    end else if (reg_addr == `ADDR_PB_DATA) begin
      wr_dat[1] = reg_wr;
    end else if (reg_addr == `ADDR_PB_DIR) begin
      wr_dir[1] = reg_wr;
    end else if (reg_addr == `ADDR_PB_PU) begin
      wr_pu[1] = reg_wr;
    end else if (reg_addr == `ADDR_PC_DATA) begin
      wr_dat[2] = reg_wr;
    end else if (reg_addr == `ADDR_PC_DIR) begin
      wr_dir[2] = reg_wr;
    end else if (reg_addr == `ADDR_PC_PU) begin
      wr_pu[2] = reg_wr;
    end else if (reg_addr == `ADDR_PD_DATA) begin
      wr_dat[3] = reg_wr;
    end else if (reg_addr == `ADDR_PD_DIR) begin
      wr_dir[3] = reg_wr;
    end else if (reg_addr == `ADDR_PD_PU) begin
      wr_pu[3] = reg_wr;
    end else if (reg_addr == `ADDR_PE_DATA) begin
      wr_dat[4] = reg_wr;
    end else if (reg_addr == `ADDR_PE_DIR) begin
      wr_dir[4] = reg_wr;
    end else if (reg_addr == `ADDR_PE_PU) begin
      wr_pu[4] = reg_wr;
    end else if (reg_addr == `ADDR_SRC_AB) begin
      wr_s0 = reg_wr;
    end else if (reg_addr == `ADDR_SRC_CD) begin
      wr_s1 = reg_wr;
    end else if (reg_addr == `ADDR_SRC_MISC) begin
      wr_s2 = reg_wr;
    end
  end

  // output latches, written regardless of direction
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dat_q <= `DATA_RST;
    end else begin
      for (int i = 0; i < 5; i++) begin
        if (wr_dat[i]) begin
          dat_q[i] <= reg_wdata & impl[i];
        end
      end
    end
  end

  // direction bits, all inputs out of reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dir_q <= `DIR_RST;
    end else begin
      for (int i = 0; i < 5; i++) begin
        if (wr_dir[i]) begin
          dir_q[i] <= reg_wdata & impl[i];
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pu_q <= `PU_RST;
    end else begin
      for (int i = 0; i < 5; i++) begin
        if (wr_pu[i]) begin
          pu_q[i] <= reg_wdata & impl[i];
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_q <= `WAKE_RST;
    end else if (wr_wake) begin
      wake_q <= reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      src_ab_q <= `SRC_RST;
      src_cd_q <= `SRC_RST;
      src_misc_q <= `SRC_RST;
    end else begin
      if (wr_s0) begin
        src_ab_q <= reg_wdata;
      end
      if (wr_s1) begin
        src_cd_q <= reg_wdata;
      end
      if (wr_s2) begin
        src_misc_q <= reg_wdata & `SRC_MISC_MASK;
      end
    end
  end

  // inputs read live, outputs read their latch
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      port_rd[i] = (dir_q[i] & pin[i]) | (~dir_q[i] & dat_q[i]);
    end
  end

  // read decode
  always_comb begin
    rd_val = '0;
    if (reg_addr == `ADDR_PA_DATA) begin
      rd_val = port_rd[0];
    end else if (reg_addr == `ADDR_PA_DIR) begin
      rd_val = dir_q[0];
    end else if (reg_addr == `ADDR_PA_PU) begin
      rd_val = pu_q[0];
    end else if (reg_addr == `ADDR_PA_WAKE) begin
      rd_val = wake_q;
    end else if (reg_addr == `ADDR_PB_DATA) begin
      rd_val = port_rd[1];
    end else if (reg_addr == `ADDR_PB_DIR) begin
      rd_val = dir_q[1];
    end else if (reg_addr == `ADDR_PB_PU) begin
      rd_val = pu_q[1];
    end else if (reg_addr == `ADDR_PC_DATA) begin
      rd_val = port_rd[2];
    end else if (reg_addr == `ADDR_PC_DIR) begin
      rd_val = dir_q[2];
    end else if (reg_addr == `ADDR_PC_PU) begin
      rd_val = pu_q[2];
    end else if (reg_addr == `ADDR_PD_DATA) begin
      rd_val = port_rd[3];
    end else if (reg_addr == `ADDR_PD_DIR) begin
      rd_val = dir_q[3];
    end else if (reg_addr == `ADDR_PD_PU) begin
      rd_val = pu_q[3];
    end else if (reg_addr == `ADDR_PE_DATA) begin
      rd_val = port_rd[4];
    end else if (reg_addr == `ADDR_PE_DIR) begin
      rd_val = dir_q[4];
    end else if (reg_addr == `ADDR_PE_PU) begin
      rd_val = pu_q[4];
    end else if (reg_addr == `ADDR_SRC_AB) begin
      rd_val = src_ab_q;
    end else if (reg_addr == `ADDR_SRC_CD) begin
      rd_val = src_cd_q;
    end else if (reg_addr == `ADDR_SRC_MISC) begin
      rd_val = src_misc_q;
    end
  end

  // pin level captured on the edge that takes the read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= `RDATA_RST;
    end else if (reg_rd) begin
      reg_rdata <= rd_val;
    end
  end

  // port a falling edges, gated by input mode and sleep
  assign pa_fall = pa_prev_q & ~pa_in & wake_q & dir_q[0]
                   & {8{sleep_mode}};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pa_prev_q <= `PIN_HIGH_RST;
    end else begin
      pa_prev_q <= pa_in;
    end
  end

  // request holds until the core leaves sleep; a new edge wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_req_q <= 1'b0;
    end else if (|pa_fall) begin
      wake_req_q <= 1'b1;
    end else if (!sleep_mode) begin
      wake_req_q <= 1'b0;
    end
  end

  assign wake_req = wake_req_q;

  // pin drivers
  io_pin_cell #(.W(8)) u_pa (
    .clk(clk), .rst_n(rst_n), .dir(dir_q[0]), .latch(dat_q[0]),
    .pu(pu_q[0]), .src(src_ab_q[3:0]), .pin_out(pa_out),
    .pin_oe(pa_oe), .pu_en(pa_pu_en), .src_sel(pa_src_sel)
  );

  io_pin_cell #(.W(8)) u_pb (
    .clk(clk), .rst_n(rst_n), .dir(dir_q[1]), .latch(dat_q[1]),
    .pu(pu_q[1]), .src(src_ab_q[7:4]), .pin_out(pb_out),
    .pin_oe(pb_oe), .pu_en(pb_pu_en), .src_sel(pb_src_sel)
  );

  io_pin_cell #(.W(8)) u_pc (
    .clk(clk), .rst_n(rst_n), .dir(dir_q[2]), .latch(dat_q[2]),
    .pu(pu_q[2]), .src(src_cd_q[3:0]), .pin_out(pc_out),
    .pin_oe(pc_oe), .pu_en(pc_pu_en), .src_sel(pc_src_sel)
  );

  io_pin_cell #(.W(8)) u_pd (
    .clk(clk), .rst_n(rst_n), .dir(dir_q[3]), .latch(dat_q[3]),
    .pu(pu_q[3]), .src(src_cd_q[7:4]), .pin_out(pd_out),
    .pin_oe(pd_oe), .pu_en(pd_pu_en), .src_sel(pd_src_sel)
  );

  io_pin_cell #(.W(4)) u_pe (
    .clk(clk), .rst_n(rst_n), .dir(dir_q[4][3:0]),
    .latch(dat_q[4][3:0]), .pu(pu_q[4][3:0]), .src(src_misc_q[1:0]),
    .pin_out(pe_out), .pin_oe(pe_oe), .pu_en(pe_pu_en),
    .src_sel(pe_src_sel)
  );

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_input_read: assert property (
    reg_rd && reg_addr == `ADDR_PA_DATA && dir_q[0] == 8'hFF
    |=> reg_rdata == $past(pa_in))
    else $error("input pin read wrong");

  a_output_drive: assert property (
    !dir_q[0][0] |=> pa_oe[0] && pa_out[0] == $past(dat_q[0][0]))
    else $error("output pin not driven from latch");

  a_output_readback: assert property (
    reg_rd && reg_addr == `ADDR_PB_DATA && dir_q[1] == 8'h00
    |=> reg_rdata == $past(dat_q[1]))
    else $error("output read is not latch");

  a_read_sample: assert property (
    reg_rd && reg_addr == `ADDR_PD_DATA && dir_q[3] == 8'hFF
    |=> reg_rdata == $past(pd_in))
    else $error("read not sampled at take edge");

  a_latch_hold: assert property (
    !wr_dat[0] |=> dat_q[0] == $past(dat_q[0]))
    else $error("latch changed without write");

  a_dir_dynamic: assert property (
    wr_dir[1] |=> ##1 pb_oe == ~$past(reg_wdata, 2))
    else $error("direction change not applied");

  a_pullup_gate: assert property (
    1'b1 |=> pa_pu_en == $past(pu_q[0] & dir_q[0]))
    else $error("pull-high not gated by input");

  a_wake_raise: assert property (
    |pa_fall |=> wake_req)
    else $error("wake not raised on edge");

  a_wake_ignored: assert property (
    !sleep_mode |=> !wake_req)
    else $error("wake raised outside sleep");

  a_pe_upper: assert property (
    reg_rd && reg_addr == `ADDR_PE_DATA |=> reg_rdata[7:4] == 4'h0)
    else $error("port e upper bits not zero");

  a_src_gate: assert property (
    dir_q[2][0] |=> pc_src_sel[1:0] == `SRC_OFF)
    else $error("source select active on input");

  c_wake: cover property (sleep_mode && |pa_fall ##1 wake_req);
  c_out_read: cover property (wr_dir[1] ##2 reg_rd);
  c_pe_write: cover property (wr_dat[4] && reg_wdata == 8'hFF);

endmodule

`default_nettype wire

// file: pin_world.sv
`timescale 1ns/100ps
`default_nettype none

module pin_world #(
  parameter int unsigned W = 8
) (
  input wire logic clk,
  input wire logic [W-1:0] pin_out,
  input wire logic [W-1:0] pin_oe,
  input wire logic [W-1:0] pin_pu_en,
  input wire logic [W-1:0] ext_val,
  input wire logic [W-1:0] ext_en,
  output logic [W-1:0] pin_in
);
  logic [W-1:0] float_q = '0;

  // undriven line wanders every cycle
  always @(posedge clk) begin
    float_q <= ~float_q;
  end

  // a strong outside drive beats the cell, for read-back cases
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (ext_en[i])
        pin_in[i] = ext_val[i];
      else if (pin_oe[i])
        pin_in[i] = pin_out[i];
      else if (pin_pu_en[i])
        pin_in[i] = 1'b1;
      else
        pin_in[i] = float_q[i];
    end
  end
endmodule

`default_nettype wire

// file: bidir_io_ports_test.sv
`timescale 1ns/100ps
`default_nettype none
`include "io_ports_cfg.svh"

module bidir_io_ports_test;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic sleep_mode = 1'b0;
  logic [7:0] reg_rdata;
  logic wake_req;
  logic [7:0] pa_in, pa_out, pa_oe, pa_pu_en, pa_ext, pa_ext_en;
  logic [7:0] pb_in, pb_out, pb_oe, pb_pu_en, pb_ext, pb_ext_en;
  logic [7:0] pc_in, pc_out, pc_oe, pc_pu_en, pc_ext, pc_ext_en;
  logic [7:0] pd_in, pd_out, pd_oe, pd_pu_en, pd_ext, pd_ext_en;
  logic [3:0] pe_in, pe_out, pe_oe, pe_pu_en, pe_ext, pe_ext_en;
  logic [15:0] pa_src_sel, pb_src_sel, pc_src_sel, pd_src_sel;
  logic [7:0] pe_src_sel;
  int n_errors = 0;
  int n_checks = 0;
  logic [7:0] dat_a [5] = '{`ADDR_PA_DATA, `ADDR_PB_DATA, `ADDR_PC_DATA,
                            `ADDR_PD_DATA, `ADDR_PE_DATA};
  logic [7:0] dir_a [5] = '{`ADDR_PA_DIR, `ADDR_PB_DIR, `ADDR_PC_DIR,
                            `ADDR_PD_DIR, `ADDR_PE_DIR};
  logic [7:0] pu_a [5] = '{`ADDR_PA_PU, `ADDR_PB_PU, `ADDR_PC_PU,
                           `ADDR_PD_PU, `ADDR_PE_PU};
  logic [7:0] msk [5] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h0F};
  logic [7:0] ext_v [5] = '{8'hA5, 8'h3C, 8'h96, 8'h0F, 8'h06};

  bidir_io_ports bidir_io_ports_i (
    .clk, .rst_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
    .sleep_mode, .wake_req,
    .pa_in, .pa_out, .pa_oe, .pa_pu_en, .pa_src_sel,
    .pb_in, .pb_out, .pb_oe, .pb_pu_en, .pb_src_sel,
    .pc_in, .pc_out, .pc_oe, .pc_pu_en, .pc_src_sel,
    .pd_in, .pd_out, .pd_oe, .pd_pu_en, .pd_src_sel,
    .pe_in, .pe_out, .pe_oe, .pe_pu_en, .pe_src_sel
  );

  pin_world #(.W(8)) pin_world_a_i (.clk, .pin_out(pa_out), .pin_oe(pa_oe),
    .pin_pu_en(pa_pu_en), .ext_val(pa_ext), .ext_en(pa_ext_en), .pin_in(pa_in));
  pin_world #(.W(8)) pin_world_b_i (.clk, .pin_out(pb_out), .pin_oe(pb_oe),
    .pin_pu_en(pb_pu_en), .ext_val(pb_ext), .ext_en(pb_ext_en), .pin_in(pb_in));
  pin_world #(.W(8)) pin_world_c_i (.clk, .pin_out(pc_out), .pin_oe(pc_oe),
    .pin_pu_en(pc_pu_en), .ext_val(pc_ext), .ext_en(pc_ext_en), .pin_in(pc_in));
  pin_world #(.W(8)) pin_world_d_i (.clk, .pin_out(pd_out), .pin_oe(pd_oe),
    .pin_pu_en(pd_pu_en), .ext_val(pd_ext), .ext_en(pd_ext_en), .pin_in(pd_in));
  pin_world #(.W(4)) pin_world_e_i (.clk, .pin_out(pe_out), .pin_oe(pe_oe),
    .pin_pu_en(pe_pu_en), .ext_val(pe_ext), .ext_en(pe_ext_en), .pin_in(pe_in));

  always #2 clk = ~clk;

  task automatic chk(input string nm, input logic [39:0] s, input logic [39:0] e);
    n_checks++;
    if (s !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    chk($sformatf("reg %h", a), reg_rdata, e);
  endtask

  task automatic settle();
    repeat (2) @(negedge clk);
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic t_reset();
    for (int p = 0; p < 5; p++) begin
      rdchk(dir_a[p], msk[p]);
      rdchk(pu_a[p], 8'h00);
    end
    rdchk(`ADDR_PA_WAKE, 8'h00);
    rdchk(`ADDR_SRC_AB, 8'h00);
    rdchk(`ADDR_SRC_CD, 8'h00);
    rdchk(`ADDR_SRC_MISC, 8'h00);
    chk("oe", {pa_oe, pb_oe, pc_oe, pd_oe, pe_oe}, 40'h0);
    chk("pu_en", {pa_pu_en, pb_pu_en, pc_pu_en, pd_pu_en, pe_pu_en}, 40'h0);
    chk("src", |{pa_src_sel, pb_src_sel, pc_src_sel, pd_src_sel, pe_src_sel}, 40'h0);
    $display("done reset");
  endtask

  task automatic t_input();
    for (int p = 0; p < 5; p++) begin
      rdchk(dat_a[p], ext_v[p]);
    end
    @(negedge clk);
    reg_addr = `ADDR_PA_DATA;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    pa_ext = 8'h5A;
    @(negedge clk);
    chk("sampled", reg_rdata, 8'hA5);
    $display("done input");
  endtask

  task automatic t_output();
    pa_ext = 8'h00;
    wr(`ADDR_PA_DATA, 8'h3C);
    settle();
    chk("latch while input", {pa_oe, pa_out}, 16'h003C);
    wr(`ADDR_PA_DIR, 8'hF0);
    settle();
    chk("half out", {pa_oe, pa_out}, 16'h0F3C);
    rdchk(`ADDR_PA_DATA, 8'h0C);
    wr(`ADDR_PA_DIR, 8'h00);
    wr(`ADDR_PB_DATA, 8'h55);
    wr(`ADDR_PA_PU, 8'hFF);
    settle();
    chk("latch held", {pa_oe, pa_out}, 16'hFF3C);
    rdchk(`ADDR_PA_DATA, 8'h3C);
    $display("done output");
  endtask

  task automatic t_pullup();
    wr(`ADDR_PA_DIR, 8'hF0);
    settle();
    chk("pu_en", pa_pu_en, 8'hF0);
    rdchk(`ADDR_PA_PU, 8'hFF);
    pa_ext_en = 8'h00;
    rdchk(`ADDR_PA_DATA, 8'hFC);
    $display("done pullup");
  endtask

  task automatic t_wake();
    int n;
    wr(`ADDR_PA_DIR, 8'h01);
    wr(`ADDR_PA_WAKE, 8'h03);
    pa_ext = 8'h01;
    pa_ext_en = 8'h01;
    settle();
    pa_ext = 8'h00;
    settle();
    chk("wake awake", wake_req, 1'b0);
    pa_ext = 8'h01;
    settle();
    sleep_mode = 1'b1;
    pa_ext = 8'h03;
    pa_ext_en = 8'h03;
    settle();
    pa_ext = 8'h01;
    settle();
    chk("wake output pin", wake_req, 1'b0);
    pa_ext = 8'h00;
    n = 0;
    while (wake_req !== 1'b1 && n < 8) begin
      @(negedge clk);
      n++;
    end
    if (wake_req !== 1'b1) begin
      n_errors++;
      conclude();
    end
    chk("wake", wake_req, 1'b1);
    sleep_mode = 1'b0;
    settle();
    chk("wake cleared", wake_req, 1'b0);
    $display("done wake");
  endtask

  task automatic t_porte();
    wr(`ADDR_PE_DIR, 8'hF0);
    rdchk(`ADDR_PE_DIR, 8'h00);
    wr(`ADDR_PE_DATA, 8'hFA);
    rdchk(`ADDR_PE_DATA, 8'h0A);
    wr(`ADDR_PE_PU, 8'hFF);
    rdchk(`ADDR_PE_PU, 8'h0F);
    wr(`ADDR_PD_DIR, 8'h7F);
    settle();
    chk("unbonded", {pd_oe[7], pe_oe, pe_out}, 9'h1FA);
    wr(8'h20, 8'hFF);
    rdchk(8'h20, 8'h00);
    wr(`ADDR_SRC_MISC, 8'hFF);
    rdchk(`ADDR_SRC_MISC, 8'h03);
    $display("done port e");
  endtask

  task automatic t_src();
    wr(`ADDR_PA_DIR, 8'h00);
    wr(`ADDR_PB_DIR, 8'h0F);
    wr(`ADDR_SRC_AB, 8'hE4);
    wr(`ADDR_PC_DIR, 8'h00);
    wr(`ADDR_SRC_CD, 8'h1B);
    settle();
    chk("src a", pa_src_sel, 16'h5500);
    chk("src b", pb_src_sel, 16'hFF00);
    chk("src c", pc_src_sel, 16'hAAFF);
    chk("src d", pd_src_sel, 16'h0000);
    chk("src e", pe_src_sel, 8'hFF);
    wr(`ADDR_PB_DIR, 8'h00);
    wr(`ADDR_PD_DIR, 8'h00);
    settle();
    chk("src b out", pb_src_sel, 16'hFFAA);
    chk("src d out", pd_src_sel, 16'h0055);
    chk("outs", {pb_oe, pb_out, pc_out, pd_out}, 32'hFF55FFFF);
    rdchk(`ADDR_PB_DATA, 8'h55);
    $display("done source current");
  endtask

  initial begin
    pa_ext = ext_v[0];
    pb_ext = ext_v[1];
    pc_ext = ext_v[2];
    pd_ext = ext_v[3];
    pe_ext = ext_v[4][3:0];
    pa_ext_en = 8'hFF;
    pb_ext_en = 8'hFF;
    pc_ext_en = 8'hFF;
    pd_ext_en = 8'hFF;
    pe_ext_en = 4'hF;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    t_reset();
    t_input();
    t_output();
    t_pullup();
    t_wake();
    t_porte();
    t_src();
    conclude();
  end
endmodule

`default_nettype wire
